// ---- hw/dmsd_core.sv ----
/*
  Mode handling for the drive: cyclic synchronous velocity and torque,
  step/direction pulse input with scaling and two subtypes, and the
  auto-setup start and flags.
  Assumes pins i_pins are asynchronous; every other input comes from
  logic on i_clk. Object accesses are single-cycle strobes.
*/
`timescale 1ns/1ps

module dmsd_core
  import dmsd_pkg::*;
#(
  parameter int P_MS_CYCLES = dmsd_pkg::MS_CYCLES
)(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire dmsd_pkg::dmsd_od_req_t i_od,
  output dmsd_pkg::dmsd_od_rsp_t     o_od,
  input  wire logic [4:0]            i_pins,
  input  wire logic                  i_closed_loop,
  input  wire logic                  i_setpoint_wr,
  input  wire logic [31:0]           i_setpoint,
  input  wire logic [15:0]           i_cycle_period,
  input  wire logic [7:0]            i_cycle_index,
  input  wire logic                  i_ferr_outside,
  input  wire logic [15:0]           i_ferr_timeout_ms,
  input  wire logic                  i_setup_done,
  input  wire logic [7:0]            i_pole_pairs,
  output logic [15:0]                o_status_word,
  output logic [31:0]                o_demand_pos,
  output logic [31:0]                o_step_width,
  output logic [31:0]                o_setpoint,
  output logic                       o_setpoint_active,
  output logic                       o_setup_start,
  output logic                       o_limit_hit,
  output logic [31:0]                o_units_per_rev
);
  import dmsd_pkg::*;

  // ----------------------------------------------------------------
  // state and decoded conditions
  // ----------------------------------------------------------------
  dmsd_state_t st_ff;
  dmsd_state_t nxt_st;
  logic        is_cyclic;
  logic        is_stepdir;
  logic        clk_rise;
  logic        dir_rise;
  logic        idx_rise;
  logic        step_fwd;
  logic        step_rev;
  logic        blk_fwd;
  logic        blk_rev;

  // edges seen on the synchronised pins
  assign is_cyclic  = (st_ff.mode == MODE_CSV) || (st_ff.mode == MODE_CST);
  assign is_stepdir = (st_ff.mode == MODE_STEPDIR);
  assign clk_rise   = st_ff.s2[PIN_CLK] & ~st_ff.s3[PIN_CLK];
  assign dir_rise   = st_ff.s2[PIN_DIR] & ~st_ff.s3[PIN_DIR];
  assign idx_rise   = st_ff.s2[PIN_IDX] & ~st_ff.s3[PIN_IDX];

  // pulse decode per subtype
  always_comb
  begin
    step_fwd = 1'b0;
    step_rev = 1'b0;
    if (is_stepdir && st_ff.sub == SUB_PULSE_PLUS_LEVEL)
    begin
      step_fwd = clk_rise & st_ff.s2[PIN_DIR];
      step_rev = clk_rise & ~st_ff.s2[PIN_DIR];
    end
    else if (is_stepdir && st_ff.sub == SUB_TWO_INPUT_ROT)
    begin
      step_fwd = clk_rise;
      step_rev = dir_rise;
    end
  end

  // limit switches block travel toward them
  assign blk_fwd = st_ff.s2[PIN_LIMP];
  assign blk_rev = st_ff.s2[PIN_LIMN];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [32:0] sh;
    logic        qbit;
    logic [15:0] sw;
    logic        sp_blk;
    sh     = 33'h0_0000_0000;
    qbit   = 1'b0;
    sw     = 16'h0000;
    sp_blk = 1'b0;
    nxt_st = st_ff;
    nxt_st.od.ack      = 1'b0;
    nxt_st.setup_start = 1'b0;
    nxt_st.ms_tick     = 1'b0;

    // two-flop pin synchroniser plus edge stage
    nxt_st.s1 = i_pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;

    // 1 ms time base
    if (st_ff.ms_cnt >= 16'(P_MS_CYCLES - 1))
    begin
      nxt_st.ms_cnt  = 16'h0000;
      nxt_st.ms_tick = 1'b1;
    end
    else
    begin
      nxt_st.ms_cnt = st_ff.ms_cnt + 16'h0001;
    end

    // step width divider, one quotient bit per cycle
    if (st_ff.div_busy)
    begin
      sh = {st_ff.div_rem, st_ff.div_quo[31]};
      if (sh >= {1'b0, st_ff.den})
      begin
        sh   = sh - {1'b0, st_ff.den};
        qbit = 1'b1;
      end
      nxt_st.div_rem = sh[31:0];
      nxt_st.div_quo = {st_ff.div_quo[30:0], qbit};
      nxt_st.div_cnt = st_ff.div_cnt + 6'h01;
      if (st_ff.div_cnt == 6'(DIV_STEPS - 1))
      begin
        nxt_st.div_busy = 1'b0;
        nxt_st.step_w   = {st_ff.div_quo[30:0], qbit};
      end
    end

    // object writes; a scaling write restarts the divider
    if (i_od.wr)
    begin
      case (i_od.index)
        OD_STEP_NUM:     nxt_st.num  = i_od.wdata;
        OD_STEP_DEN:     nxt_st.den  = i_od.wdata;
        OD_STEP_SUBTYPE: nxt_st.sub  = i_od.wdata;
        OD_CTRL_WORD:    nxt_st.ctrl = i_od.wdata[15:0];
        OD_MODE_SELECT:  nxt_st.mode = i_od.wdata[7:0];
        default:         nxt_st.ctrl = st_ff.ctrl;
      endcase
      if (i_od.index == OD_STEP_NUM || i_od.index == OD_STEP_DEN)
      begin
        nxt_st.div_busy = 1'b1;
        nxt_st.div_cnt  = 6'h00;
        nxt_st.div_rem  = 32'h0000_0000;
        nxt_st.div_quo  = (i_od.index == OD_STEP_NUM) ? i_od.wdata : st_ff.num;
        if ((i_od.index == OD_STEP_DEN) && (i_od.wdata == 32'h0000_0000))
        begin
          nxt_st.div_busy = 1'b0; // zero divisor gives no motion
          nxt_st.step_w   = 32'h0000_0000;
        end
      end
    end

    // object reads; unknown index reads zero
    nxt_st.od.ack = i_od.wr | i_od.rd;
    if (i_od.rd)
    begin
      case (i_od.index)
        OD_STEP_NUM:     nxt_st.od.rdata = st_ff.num;
        OD_STEP_DEN:     nxt_st.od.rdata = st_ff.den;
        OD_STEP_SUBTYPE: nxt_st.od.rdata = st_ff.sub;
        OD_CTRL_WORD:    nxt_st.od.rdata = {16'h0000, st_ff.ctrl};
        OD_STATUS_WORD:  nxt_st.od.rdata = {16'h0000, st_ff.status};
        OD_MODE_SELECT:  nxt_st.od.rdata = {24'h00_0000, st_ff.mode};
        default:         nxt_st.od.rdata = 32'h0000_0000;
      endcase
    end

    // step accumulation into demand position
    if (step_fwd && !blk_fwd && !(step_rev && !blk_rev))
    begin
      nxt_st.pos = st_ff.pos + st_ff.step_w;
    end
    else if (step_rev && !blk_rev && !(step_fwd && !blk_fwd))
    begin
      nxt_st.pos = st_ff.pos - st_ff.step_w;
    end
    nxt_st.limit_hit = blk_fwd | blk_rev;

    // cyclic setpoint capture and sync tracking
    if (i_setpoint_wr)
    begin
      nxt_st.setpoint = i_setpoint;
      nxt_st.cyc_cnt  = 16'h0000;
      nxt_st.synced   = is_cyclic && (i_cycle_index == TIME_INDEX_MS)
                        && (i_cycle_period != 16'h0000) && (st_ff.cyc_cnt <= i_cycle_period);
    end
    else if (st_ff.ms_tick)
    begin
      if (st_ff.cyc_cnt != 16'hFFFF)
      begin
        nxt_st.cyc_cnt = st_ff.cyc_cnt + 16'h0001;
      end
      if (st_ff.cyc_cnt >= i_cycle_period)
      begin
        nxt_st.synced = 1'b0;
      end
    end
    if (!is_cyclic || i_cycle_index != TIME_INDEX_MS)
    begin
      nxt_st.synced = 1'b0;
    end

    // setpoint used only when synced, mode valid and not into a limit
    sp_blk = (blk_fwd & ~st_ff.setpoint[31]) | (blk_rev & st_ff.setpoint[31]);
    nxt_st.sp_act = st_ff.synced && !sp_blk
                    && ((st_ff.mode == MODE_CSV) || ((st_ff.mode == MODE_CST) && i_closed_loop));

    // following error timer in closed-loop step mode
    if (is_stepdir && i_closed_loop && i_ferr_outside)
    begin
      if (st_ff.ms_tick && st_ff.ferr_cnt != 16'hFFFF)
      begin
        nxt_st.ferr_cnt = st_ff.ferr_cnt + 16'h0001;
      end
      if (st_ff.ferr_cnt > i_ferr_timeout_ms)
      begin
        nxt_st.ferr = 1'b1;
      end
    end
    else
    begin
      nxt_st.ferr_cnt = 16'h0000;
      nxt_st.ferr     = 1'b0;
    end

    // control bit 4 is only decoded in auto-setup
    nxt_st.cw4_prev = st_ff.ctrl[CW_START_BIT];
    case (st_ff.phase)
      SU_IDLE, SU_DONE:
      begin
        if ((st_ff.mode == MODE_SETUP) && st_ff.ctrl[CW_START_BIT] && !st_ff.cw4_prev
            && !blk_fwd && !blk_rev)
        begin
          nxt_st.phase       = SU_RUN;
          nxt_st.setup_start = 1'b1;
          nxt_st.indexed     = 1'b0;
          nxt_st.aligned     = 1'b0;
        end
      end
      SU_RUN:
      begin
        if (idx_rise)
        begin
          nxt_st.indexed = 1'b1;
        end
        if (i_setup_done)
        begin
          nxt_st.phase   = SU_DONE;
          nxt_st.aligned = 1'b1;
        end
        else if (st_ff.mode != MODE_SETUP)
        begin
          nxt_st.phase = SU_IDLE;
        end
      end
      default: nxt_st.phase = SU_IDLE;
    endcase

    // revolution length in position units
    nxt_st.upr = 32'(i_pole_pairs) * 32'(STEPS_PER_POLE_PAIR * FULL_STEP_UNITS);

    // status word assembly per mode
    if (is_cyclic)
    begin
      sw[SW_SYNC_BIT]   = st_ff.synced;
      sw[SW_TARGET_BIT] = st_ff.sp_act;
    end
    else if (is_stepdir)
    begin
      sw[SW_FERR_BIT] = st_ff.ferr;
    end
    else if (st_ff.mode == MODE_SETUP)
    begin
      sw[SW_INDEX_BIT]  = st_ff.indexed;
      sw[SW_TARGET_BIT] = st_ff.aligned;
    end
    nxt_st.status = sw;
  end

  // single state register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff      <= '0;
      st_ff.num  <= STEP_NUM_RST;
      st_ff.den  <= STEP_DEN_RST;
      st_ff.sub  <= SUBTYPE_RST;
      st_ff.ctrl <= CTRL_RST;
      st_ff.mode <= MODE_RST;
      st_ff.step_w <= STEP_NUM_RST;
      st_ff.phase  <= SU_IDLE;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign o_od              = st_ff.od;
  assign o_status_word     = st_ff.status;
  assign o_demand_pos      = st_ff.pos;
  assign o_step_width      = st_ff.step_w;
  assign o_setpoint        = st_ff.setpoint;
  assign o_setpoint_active = st_ff.sp_act;
  assign o_setup_start     = st_ff.setup_start;
  assign o_limit_hit       = st_ff.limit_hit;
  assign o_units_per_rev   = st_ff.upr;

  // ----------------------------------------------------------------
  // assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_step_fwd_adds: assert property (step_fwd && !blk_fwd && !step_rev |=>
    st_ff.pos == $past(st_ff.pos) + $past(st_ff.step_w)) else $error("forward step not added");
  a_sub0_rev_level: assert property (is_stepdir && st_ff.sub == 32'h0000_0000 && clk_rise
    && !st_ff.s2[PIN_DIR] && !blk_rev |=> st_ff.pos == $past(st_ff.pos) - $past(st_ff.step_w))
    else $error("subtype 0 low direction did not step back");
  a_sub1_ccw_input: assert property (is_stepdir && st_ff.sub == 32'h0000_0001 && dir_rise
    && !clk_rise && !blk_rev |=> st_ff.pos == $past(st_ff.pos) - $past(st_ff.step_w))
    else $error("subtype 1 second input did not step back");
  a_limit_holds_pos: assert property (step_fwd && blk_fwd && !step_rev |=> $stable(st_ff.pos))
    else $error("step taken into positive limit");
  a_width_quotient: assert property ($fell(st_ff.div_busy) && st_ff.den != 32'h0000_0000
    |-> st_ff.step_w == st_ff.num / st_ff.den) else $error("step width not num over den");
  a_bad_index_nosync: assert property (i_setpoint_wr && i_cycle_index != TIME_INDEX_MS
    |=> !st_ff.synced) else $error("synced with unsupported time index");
  a_sync_bit_mode: assert property (o_status_word[SW_SYNC_BIT] |-> $past(is_cyclic))
    else $error("sync bit outside cyclic modes");
  a_target_bit_copy: assert property (is_cyclic |=> o_status_word[SW_TARGET_BIT] == $past(st_ff.sp_act))
    else $error("target bit disagrees with setpoint use");
  a_torque_loop: assert property (st_ff.mode == MODE_CST && !i_closed_loop |=> !o_setpoint_active)
    else $error("torque setpoint used without closed loop");
  a_active_modes: assert property (o_setpoint_active |-> $past(is_cyclic))
    else $error("setpoint active outside cyclic modes");
  a_ferr_loop: assert property (!i_closed_loop |=> !st_ff.ferr)
    else $error("following error without closed loop");
  a_start_on_edge: assert property (st_ff.setup_start |-> $past(st_ff.ctrl[CW_START_BIT])
    && !$past(st_ff.cw4_prev) && $past(st_ff.mode) == MODE_SETUP) else $error("setup start without edge");
  a_done_aligned: assert property (st_ff.phase == SU_RUN && i_setup_done |=> st_ff.aligned
    ##0 st_ff.phase == SU_DONE) else $error("setup done did not align");

  c_fwd_step:    cover property (step_fwd && !blk_fwd ##1 $changed(st_ff.pos));
  c_ccw_input:   cover property (is_stepdir && st_ff.sub == 32'h0000_0001 && dir_rise);
  c_setup_run:   cover property (st_ff.setup_start ##[1:200] st_ff.aligned);
  c_sync_gained: cover property ($rose(o_status_word[SW_SYNC_BIT]));

endmodule

// ---- inc/dmsd_pkg.sv ----
/*
  Package for the drive mode / step-direction block: object indices,
  reset values, mode codes, status and control bit positions, timing
  counts and the carrier types.
  Assumes a 50 MHz core clock and an object-access port from the
  fieldbus stack on the same clock.
*/
package dmsd_pkg;

  // ----------------------------------------------------------------
  // object dictionary indices
  // ----------------------------------------------------------------
  localparam logic [15:0] OD_STEP_NUM     = 16'h2057;
  localparam logic [15:0] OD_STEP_DEN     = 16'h2058;
  localparam logic [15:0] OD_STEP_SUBTYPE = 16'h205B;
  localparam logic [15:0] OD_CTRL_WORD    = 16'h6040;
  localparam logic [15:0] OD_STATUS_WORD  = 16'h6041;
  localparam logic [15:0] OD_MODE_SELECT  = 16'h6060;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] STEP_NUM_RST = 32'h0000_0080;
  localparam logic [31:0] STEP_DEN_RST = 32'h0000_0001;
  localparam logic [31:0] SUBTYPE_RST  = 32'h0000_0000;
  localparam logic [15:0] CTRL_RST     = 16'h0000;
  localparam logic [7:0]  MODE_RST     = 8'h00;

  // ----------------------------------------------------------------
  // mode codes, subtypes, bit positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  MODE_CSV     = 8'h09;
  localparam logic [7:0]  MODE_CST     = 8'h0A;
  localparam logic [7:0]  MODE_STEPDIR = 8'hFF;
  localparam logic [7:0]  MODE_SETUP   = 8'hFE;
  localparam logic [31:0] SUB_PULSE_PLUS_LEVEL = 32'h0000_0000;
  localparam logic [31:0] SUB_TWO_INPUT_ROT    = 32'h0000_0001;
  localparam logic [7:0]  TIME_INDEX_MS        = 8'hFD;
  localparam int SW_SYNC_BIT   = 8;
  localparam int SW_INDEX_BIT  = 10;
  localparam int SW_TARGET_BIT = 12;
  localparam int SW_FERR_BIT   = 13;
  localparam int CW_START_BIT  = 4;
  localparam int PIN_CLK  = 0;
  localparam int PIN_DIR  = 1;
  localparam int PIN_LIMN = 2;
  localparam int PIN_LIMP = 3;
  localparam int PIN_IDX  = 4;
  localparam int FULL_STEP_UNITS     = 512;
  localparam int STEPS_PER_POLE_PAIR = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_BASE_NS    = 1000000;
  localparam int MS_CYCLES     = MS_BASE_NS / CLK_PERIOD_NS;
  localparam int DIV_STEPS     = 32;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [31:0] wdata;
  } dmsd_od_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } dmsd_od_rsp_t;

  typedef enum logic [1:0] {
    SU_IDLE = 2'b00,
    SU_RUN  = 2'b01,
    SU_DONE = 2'b10
  } dmsd_setup_t;

  typedef struct packed {
    logic [4:0]   s1;
    logic [4:0]   s2;
    logic [4:0]   s3;
    logic [31:0]  num;
    logic [31:0]  den;
    logic [31:0]  sub;
    logic [15:0]  ctrl;
    logic         cw4_prev;
    logic [7:0]   mode;
    logic [15:0]  ms_cnt;
    logic         ms_tick;
    logic [15:0]  cyc_cnt;
    logic         synced;
    logic         sp_act;
    logic [31:0]  setpoint;
    logic [15:0]  ferr_cnt;
    logic         ferr;
    logic         div_busy;
    logic [5:0]   div_cnt;
    logic [31:0]  div_rem;
    logic [31:0]  div_quo;
    logic [31:0]  step_w;
    logic [31:0]  pos;
    dmsd_setup_t  phase;
    logic         setup_start;
    logic         indexed;
    logic         aligned;
    logic         limit_hit;
    logic [31:0]  upr;
    logic [15:0]  status;
    dmsd_od_rsp_t od;
  } dmsd_state_t;

endpackage

// ---- verification/dmsd_step_src.sv ----
/*
  step/direction source: a positioning controller driving the step and
  direction pins on a 160 ns time base.
  assumes the caller waits for steps to return before the next burst.
*/
`timescale 1ns/1ps
module dmsd_step_src (
  output logic o_step_pin,
  output logic o_dir_pin
);
  localparam int TICK_NS = 160;

  // pins idle low
  initial
  begin
    o_step_pin = 1'b0;
    o_dir_pin  = 1'b0;
  end

  // ----------------------------------------------------------------
  // pulse bursts
  // ----------------------------------------------------------------
  // two ticks high, five low: 320 ns pulse, 1.12 us period
  task automatic steps(input int n, input logic fwd, input logic two_in);
    if (two_in)
      o_dir_pin = 1'b0;
    else if (o_dir_pin !== fwd)
    begin
      o_dir_pin = fwd;
      #35000;
    end
    for (int k = 0; k < n; k++)
    begin
      #(TICK_NS);
      if (two_in && !fwd)
        o_dir_pin = 1'b1;
      else
        o_step_pin = 1'b1;
      #(2 * TICK_NS);
      o_step_pin = 1'b0;
      if (two_in)
        o_dir_pin = 1'b0;
      #(4 * TICK_NS);
    end
  endtask
endmodule

// ---- verification/test_dmsd_core.sv ----
/*
  testbench for dmsd_core: object port, step pins, cyclic setpoints,
  following error and auto-setup.
  assumes a 50-cycle millisecond and the step source model.
*/
`timescale 1ns/1ps
module test_dmsd_core;
  import dmsd_pkg::*;
  localparam int MSC = 50;
  logic         i_clk = 1'b0;
  logic         i_rst_n = 1'b0;
  dmsd_od_req_t od = '0;
  dmsd_od_rsp_t o_od;
  logic         idx = 1'b0;
  logic         limn = 1'b0;
  logic         limp = 1'b0;
  logic         step_pin;
  logic         dir_pin;
  logic         cl = 1'b0;
  logic         sp_wr = 1'b0;
  logic [31:0]  sp = '0;
  logic [15:0]  period = 16'h0002;
  logic [7:0]   cidx = 8'h00;
  logic         fout = 1'b0;
  logic [15:0]  fto = 16'h0002;
  logic         sdone = 1'b0;
  logic [7:0]   poles = 8'h00;
  logic [15:0]  status;
  logic [31:0]  dpos;
  logic [31:0]  sw;
  logic [31:0]  spo;
  logic         spa;
  logic         sst;
  logic         lhit;
  logic [31:0]  upr;
  logic [31:0]  rd;
  logic [31:0]  exp_pos = '0;
  int           mismatches = 0;
  int           n_tests = 0;
  int           cycles = 0;
  int           starts = 0;
  int           s0;

  dmsd_step_src src (.o_step_pin(step_pin), .o_dir_pin(dir_pin));

  dmsd_core #(.P_MS_CYCLES(MSC)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_od(od), .o_od(o_od),
    .i_pins({idx, limp, limn, dir_pin, step_pin}), .i_closed_loop(cl),
    .i_setpoint_wr(sp_wr), .i_setpoint(sp), .i_cycle_period(period),
    .i_cycle_index(cidx), .i_ferr_outside(fout), .i_ferr_timeout_ms(fto),
    .i_setup_done(sdone), .i_pole_pairs(poles), .o_status_word(status),
    .o_demand_pos(dpos), .o_step_width(sw), .o_setpoint(spo),
    .o_setpoint_active(spa), .o_setup_start(sst), .o_limit_hit(lhit),
    .o_units_per_rev(upr));

  // ----------------------------------------------------------------
  // clock, timeout, start pulse counter
  // ----------------------------------------------------------------
  always #10 i_clk = ~i_clk;

  // counted off the falling edge, half a cycle after launch, so the start pulse is settled
  always @(negedge i_clk)
  begin
    cycles++;
    if (sst === 1'b1)
      starts++;
    if (cycles == 40000)
    begin
      mismatches++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // strobe one cycle; ack stands until the following edge, read data until the next read
  task automatic od_acc(input logic w, input logic [15:0] ix, input logic [31:0] d);
    @(negedge i_clk);
    od = '{wr: w, rd: !w, index: ix, wdata: d};
    @(negedge i_clk);
    od.wr = 1'b0;
    od.rd = 1'b0;
    chk({31'd0, o_od.ack}, 32'h0000_0001, "ack");
    rd = o_od.rdata;
  endtask

  task automatic sp_w(input logic [31:0] v);
    @(negedge i_clk);
    sp_wr = 1'b1;
    sp = v;
    @(negedge i_clk);
    sp_wr = 1'b0;
  endtask

  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset values, read-only status, unmapped index
  task automatic t_reset();
    logic [15:0] ix [5] = '{OD_STEP_NUM, OD_STEP_DEN, OD_STEP_SUBTYPE, OD_CTRL_WORD, OD_MODE_SELECT};
    logic [31:0] rv [5] = '{STEP_NUM_RST, STEP_DEN_RST, SUBTYPE_RST, 32'h0000_0000, 32'h0000_0000};
    for (int k = 0; k < 5; k++)
    begin
      od_acc(1'b0, ix[k], '0);
      chk(rd, rv[k], "reset value");
    end
    chk(sw, 32'h0000_0080, "width reset");
    od_acc(1'b1, OD_STATUS_WORD, 32'h0000_ffff);
    od_acc(1'b0, OD_STATUS_WORD, '0);
    chk(rd, '0, "status write");
    od_acc(1'b0, 16'h1234, '0);
    chk(rd, '0, "unmapped read");
    poles = 8'h03;
    wait_cyc(3);
    chk(upr, 3 * STEPS_PER_POLE_PAIR * FULL_STEP_UNITS, "units per rev");
    $display("t_reset done");
  endtask

  // pulse plus level, scaling, signed accumulation
  task automatic t_step_tr();
    od_acc(1'b1, OD_MODE_SELECT, {24'h0, MODE_STEPDIR});
    src.steps(3, 1'b1, 1'b0);
    exp_pos += 3 * 128;
    chk(dpos, exp_pos, "forward steps");
    src.steps(2, 1'b0, 1'b0);
    exp_pos -= 2 * 128;
    chk(dpos, exp_pos, "reverse steps");
    od_acc(1'b1, OD_STEP_DEN, 32'h0000_0002);
    wait_cyc(40);
    chk(sw, 32'h0000_0040, "width 128/2");
    od_acc(1'b1, OD_STEP_NUM, 32'h0000_0200);
    wait_cyc(40);
    od_acc(1'b1, OD_STEP_DEN, 32'h0000_0001);
    wait_cyc(40);
    chk(sw, 32'h0000_0200, "width full step");
    src.steps(1, 1'b0, 1'b0);
    exp_pos -= 512;
    chk(dpos, exp_pos, "below zero");
    $display("t_step_tr done");
  endtask

  // direction chosen by the pulsed input
  task automatic t_step_cw();
    od_acc(1'b1, OD_STEP_SUBTYPE, SUB_TWO_INPUT_ROT);
    src.steps(2, 1'b1, 1'b1);
    src.steps(1, 1'b0, 1'b1);
    exp_pos += 512;
    chk(dpos, exp_pos, "two input rotation");
    od_acc(1'b1, OD_STEP_SUBTYPE, SUB_PULSE_PLUS_LEVEL);
    $display("t_step_cw done");
  endtask

  // motion toward an active limit blocked; no steps outside the mode
  task automatic t_limits();
    limp = 1'b1;
    wait_cyc(4);
    chk({31'd0, lhit}, 32'h0000_0001, "limit seen");
    src.steps(1, 1'b1, 1'b0);
    chk(dpos, exp_pos, "blocked at pos limit");
    limp = 1'b0;
    limn = 1'b1;
    src.steps(1, 1'b0, 1'b0);
    chk(dpos, exp_pos, "blocked at neg limit");
    limn = 1'b0;
    od_acc(1'b1, OD_MODE_SELECT, {24'h0, MODE_CSV});
    src.steps(1, 1'b1, 1'b0);
    chk(dpos, exp_pos, "no steps in velocity mode");
    $display("t_limits done");
  endtask

  // following error after window time
  task automatic t_ferr();
    od_acc(1'b1, OD_MODE_SELECT, {24'h0, MODE_STEPDIR});
    cl = 1'b1;
    fout = 1'b1;
    wait_cyc(MSC);
    chk({31'd0, status[SW_FERR_BIT]}, '0, "before timeout");
    wait_cyc(4 * MSC);
    chk({31'd0, status[SW_FERR_BIT]}, 32'h0000_0001, "after timeout");
    fout = 1'b0;
    wait_cyc(3);
    chk({31'd0, status[SW_FERR_BIT]}, '0, "back inside");
    cl = 1'b0;
    $display("t_ferr done");
  endtask

  // sync, target use, time index, torque needs closed loop
  task automatic t_cyclic();
    od_acc(1'b1, OD_MODE_SELECT, {24'h0, MODE_CSV});
    sp_w(32'h0000_0005);
    sp_w(32'h0000_0005);
    wait_cyc(3);
    chk({31'd0, status[SW_SYNC_BIT]}, '0, "bad time index");
    cidx = TIME_INDEX_MS;
    sp_w(32'h0000_0123);
    sp_w(32'h0000_0123);
    wait_cyc(3);
    chk({31'd0, status[SW_SYNC_BIT]}, 32'h0000_0001, "synced");
    chk({31'd0, status[SW_TARGET_BIT]}, 32'h0000_0001, "target used");
    chk(spo, 32'h0000_0123, "setpoint");
    s0 = starts;
    od_acc(1'b1, OD_CTRL_WORD, 32'h0000_0010);
    wait_cyc(4);
    chk(starts - s0, 0, "ctrl bit4 inert");
    wait_cyc(4 * MSC);
    chk({31'd0, status[SW_SYNC_BIT]}, '0, "missed cycle");
    od_acc(1'b1, OD_MODE_SELECT, {24'h0, MODE_CST});
    sp_w(32'h0000_0040);
    sp_w(32'h0000_0040);
    wait_cyc(3);
    chk({31'd0, spa}, '0, "torque open loop");
    chk({31'd0, status[SW_TARGET_BIT]}, '0, "target ignored");
    cl = 1'b1;
    sp_w(32'h0000_0040);
    wait_cyc(3);
    chk({31'd0, spa}, 32'h0000_0001, "torque closed loop");
    $display("t_cyclic done");
  endtask

  // edge start, indexed and aligned flags
  task automatic t_setup();
    od_acc(1'b1, OD_CTRL_WORD, '0);
    od_acc(1'b1, OD_MODE_SELECT, {24'h0, MODE_SETUP});
    s0 = starts;
    od_acc(1'b1, OD_CTRL_WORD, 32'h0000_0010);
    wait_cyc(4);
    chk(starts - s0, 1, "setup started");
    idx = 1'b1;
    wait_cyc(5);
    idx = 1'b0;
    wait_cyc(3);
    chk({31'd0, status[SW_INDEX_BIT]}, 32'h0000_0001, "indexed");
    sdone = 1'b1;
    wait_cyc(4);
    chk({31'd0, status[SW_TARGET_BIT]}, 32'h0000_0001, "aligned");
    od_acc(1'b1, OD_CTRL_WORD, 32'h0000_0010);
    wait_cyc(4);
    chk(starts - s0, 1, "steady level");
    $display("t_setup done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge i_clk);
    i_rst_n = 1'b1;
    t_reset();
    t_step_tr();
    t_step_cw();
    t_limits();
    t_ferr();
    t_cyclic();
    t_setup();
    summarize();
  end
endmodule
